// ===== src/rdsd_fifo.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------
// word fifo with valid/ready on both sides
// ------------------------------------------------------------------
module rdsd_fifo
  import rdsd_pkg::*;
#(
  parameter int WIDTH = 4,
  parameter int DEPTH = RDSD_FIFO_DEPTH
)
(
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic          full;
  } rdsd_fifo_state_type;

  rdsd_fifo_state_type st_r;
  rdsd_fifo_state_type st_nxt;
  logic [WIDTH-1:0]    mem [DEPTH];
  logic                push;
  logic                pop;

  // full is a flop so the source sees a registered ready
  assign in_ready  = ~st_r.full;
  assign out_valid = (st_r.count != '0);
  assign out_data  = mem[st_r.rd_ptr];
  assign push      = in_valid & ~st_r.full;
  assign pop       = out_ready & out_valid;

  // ----------------------------------------------------------------
  // pointer and count update
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    if (push)
    begin
      st_nxt.wr_ptr = (st_r.wr_ptr == AW'(DEPTH - 1)) ? '0
                      : AW'(st_r.wr_ptr + 1'b1);
    end
    if (pop)
    begin
      st_nxt.rd_ptr = (st_r.rd_ptr == AW'(DEPTH - 1)) ? '0
                      : AW'(st_r.rd_ptr + 1'b1);
    end
    if (push && !pop)
    begin
      st_nxt.count = (AW+1)'(st_r.count + 1'b1);
    end
    else if (pop && !push)
    begin
      st_nxt.count = (AW+1)'(st_r.count - 1'b1);
    end
    st_nxt.full = (st_nxt.count == (AW+1)'(DEPTH));
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[st_r.wr_ptr] <= in_data;
    end
  end
endmodule

// ===== src/rdsd_pkg.sv
package rdsd_pkg;
  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int          RDSD_UNITS       = 2;   // two mux units
  localparam int          RDSD_RATIO_W     = 8;   // switch code width
  localparam int          RDSD_HALF_W      = 9;   // holds up to 256
  localparam int          RDSD_FIFO_DEPTH  = 32;
  localparam int          RDSD_SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // divider constants
  // ----------------------------------------------------------------
  localparam logic [8:0]  RDSD_RATIO_ZERO_MAP = 9'h100; // code 0 -> 256
  localparam logic [8:0]  RDSD_HALF_RST       = 9'h100;
  localparam logic [8:0]  RDSD_CNT_RST        = 9'h000;
  localparam logic [7:0]  RDSD_CODE_RST       = 8'h00;
endpackage

// ===== src/rdsd_top.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------
// dual rate doubler with programmable sync divider
// ------------------------------------------------------------------
// Operation
// - two identical units double the data rate
// - four inputs split into two independent pairs
// - sync frequency is input clock divided by n
// - eight switch bits, switch eight least significant
// - code zero divides by 256
// - nonzero code k divides by exactly k
// - sync has 50% duty at all ratios
// - sync driven as true and inverted pair
module rdsd_top
  import rdsd_pkg::*;
#(
  parameter int UNITS      = RDSD_UNITS,
  parameter int FIFO_DEPTH = RDSD_FIFO_DEPTH
)
(
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [UNITS-1:0] first_data_input,
  input  wire logic [UNITS-1:0] second_data_input,
  input  wire logic             data_valid,
  output logic                  data_ready,
  input  wire logic             ratio_select_bit_msb,
  input  wire logic [5:0]       ratio_select_mid,
  input  wire logic             ratio_select_bit_lsb,
  output logic                  input_clock_phase,
  output logic      [UNITS-1:0] serial_out,
  output logic                  serial_valid,
  output logic                  sync_out,
  output logic                  sync_out_n
);
  localparam int WW = 2 * UNITS;

  // code 0 stands for the largest ratio
  function automatic logic [8:0] ratio_of(input logic [7:0] code);
    ratio_of = (code == RDSD_CODE_RST) ? RDSD_RATIO_ZERO_MAP
               : {1'b0, code};
  endfunction

  typedef struct packed {
    logic [7:0]       code_s1;
    logic [7:0]       code_s2;
    logic             init;
    logic [8:0]       half;
    logic [8:0]       cnt;
    logic             sync;
    logic             sync_n;
    logic             phase;
    logic [UNITS-1:0] hold_second;
    logic             hold_valid;
    logic [UNITS-1:0] sout;
    logic             sval;
  } rdsd_state_type;

  rdsd_state_type   st_r;
  rdsd_state_type   st_nxt;
  logic [7:0]       code_pin;
  logic [WW-1:0]    fifo_in;
  logic [WW-1:0]    fifo_out;
  logic             fifo_valid;
  logic             fifo_pop;

  // ----------------------------------------------------------------
  // switch code assembly and input buffer
  // ----------------------------------------------------------------
  // switch one is the msb, switch eight the lsb
  assign code_pin = {ratio_select_bit_msb, ratio_select_mid,
                     ratio_select_bit_lsb};
  // one pair per unit: {second, first} kept per word
  assign fifo_in  = {second_data_input, first_data_input};
  // a word is taken once per input clock period, at high phase start
  assign fifo_pop = ~st_r.phase;

  rdsd_fifo #(
    .WIDTH (WW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_data   (fifo_in),
    .in_valid  (data_valid),
    .in_ready  (data_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    // two-stage sync of the static switch pins
    st_nxt.code_s1 = code_pin;
    st_nxt.code_s2 = st_r.code_s1;

    // input clock: one clk cycle high, one low
    st_nxt.phase = ~st_r.phase;

    // serial mux, one bit per half period
    if (!st_r.phase)
    begin
      st_nxt.sout        = fifo_out[UNITS-1:0];
      st_nxt.hold_second = fifo_out[WW-1:UNITS];
      st_nxt.hold_valid  = fifo_valid;
      st_nxt.sval        = fifo_valid;
      if (!fifo_valid)
      begin
        st_nxt.sout = '0;                 // idle line when starved
      end
    end
    else
    begin
      st_nxt.sout = st_r.hold_valid ? st_r.hold_second
                    : '0;
      st_nxt.sval = st_r.hold_valid;
    end

    // sync divider: each half lasts n half-periods of the input
    // clock, so odd ratios still split evenly (both edges used)
    if (st_r.init || (!st_r.sync && st_r.cnt == 9'(st_r.half - 1'b1)))
    begin
      // new ratio only taken at the end of a full period
      st_nxt.half   = ratio_of(st_r.code_s2);
      st_nxt.cnt    = RDSD_CNT_RST;
      st_nxt.sync   = 1'b1;
      st_nxt.sync_n = 1'b0;
      st_nxt.init   = 1'b0;
    end
    else if (st_r.cnt == 9'(st_r.half - 1'b1))
    begin
      st_nxt.cnt    = RDSD_CNT_RST;
      st_nxt.sync   = 1'b0;
      st_nxt.sync_n = 1'b1;
    end
    else
    begin
      st_nxt.cnt = 9'(st_r.cnt + 1'b1);
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // init holds one cycle after reset; the divider then loads its first
  // ratio from the reset value of code_s2, so code 0 gives 256
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_r        <= '0;
      st_r.init   <= 1'b1;
      st_r.half   <= RDSD_HALF_RST;
      st_r.sync_n <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  assign input_clock_phase = st_r.phase;
  assign serial_out        = st_r.sout;
  assign serial_valid      = st_r.sval;
  assign sync_out          = st_r.sync;
  assign sync_out_n        = st_r.sync_n;
endmodule

// ===== verif/rdsd_source.sv
`timescale 1ns/10ps
// ------------------------------------------------
// data source feeding both units
// ------------------------------------------------
module rdsd_source
  (
  input  wire logic       clk,
  input  wire logic       data_ready,
  output logic      [1:0] first_data_input,
  output logic      [1:0] second_data_input,
  output logic            data_valid
);
  logic [3:0] q[$];
  logic       took = 1'b0;
  initial {data_valid, second_data_input, first_data_input} = 5'h00;
  // handshake sampled at the edge, acted on half a cycle later
  always @(posedge clk) took <= data_valid && data_ready;
  // a word holds until taken; with no word queued the lines flip
  always @(negedge clk)
  begin
    if (took)
      void'(q.pop_front());
    data_valid <= q.size() != 0;
    if (q.size() != 0)
      {second_data_input, first_data_input} <= q[0];
    else
      {second_data_input, first_data_input} <= ~{second_data_input, first_data_input};
  end
endmodule

// ===== verif/rdsd_top_props.sv
`timescale 1ns/10ps
// ------------------------------------------------
// stream and sync checks
// ------------------------------------------------
module rdsd_top_props
  import rdsd_pkg::*;
#(
  parameter int UNITS = RDSD_UNITS
)
(
  input wire logic             clk,
  input wire logic             srst,
  input wire logic             input_clock_phase,
  input wire logic [UNITS-1:0] serial_out,
  input wire logic             serial_valid,
  input wire logic             sync_out,
  input wire logic             sync_out_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic       prev_r;
  logic       seen_r;
  logic [9:0] run_r;
  logic [9:0] high_r;
  wire        rise = sync_out && !prev_r;
  // run length of each sync level, restarts on every change
  always_ff @(posedge clk)
  begin
    prev_r <= srst ? 1'b0 : sync_out;
    run_r  <= (srst || sync_out != prev_r) ? {9'h000, !srst} : run_r + 10'h001;
    seen_r <= !srst && (seen_r || (!sync_out && prev_r));
    if (!sync_out && prev_r)
      high_r <= run_r;
  end
  sequence s_first_bit;
    serial_valid && input_clock_phase;
  endsequence
  sequence s_second_bit;
    serial_valid && !input_clock_phase;
  endsequence
  a_sync_pair_inv: assert property (sync_out_n == !sync_out)
    else $error("sync pair not complementary");
  a_phase_toggles: assert property (!$past(srst) |->
    input_clock_phase != $past(input_clock_phase))
    else $error("input clock phase stuck");
  a_first_high: assert property ($rose(serial_valid) |-> input_clock_phase)
    else $error("stream starts in low phase");
  a_pair_whole: assert property (s_first_bit |=> s_second_bit)
    else $error("second bit missing");
  a_second_after: assert property (s_second_bit |-> $past(serial_valid))
    else $error("second bit without first");
  a_idle_zero: assert property (!serial_valid |-> serial_out == '0)
    else $error("idle stream not zero");
  // equal halves also show that no half was cut short
  a_duty_equal: assert property (rise && seen_r |-> run_r == high_r)
    else $error("sync halves differ");
  a_half_max: assert property (seen_r |-> run_r <= 10'h100)
    else $error("sync half over 256");
endmodule

bind rdsd_top rdsd_top_props #(.UNITS(UNITS)) props_i (.clk(clk), .srst(srst),
  .input_clock_phase(input_clock_phase), .serial_out(serial_out),
  .serial_valid(serial_valid), .sync_out(sync_out), .sync_out_n(sync_out_n));

// ===== verif/test_rate_doubler_with_sync_divider.sv
`timescale 1ns/10ps
// ------------------------------------------------
// rate doubler and sync divider bench
// ------------------------------------------------
module test_rate_doubler_with_sync_divider
  import rdsd_pkg::*;
;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic [1:0] fdi;
  logic [1:0] sdi;
  logic       dvalid;
  logic       dready;
  logic       msb = 1'b0;
  logic       lsb = 1'b0;
  logic [5:0] mid = 6'h00;
  logic       phase;
  logic [1:0] sout;
  logic [1:0] sec;
  logic       sval;
  logic       so;
  logic       son;
  logic       saw_full = 1'b0;
  logic [3:0] exp_q[$];
  logic [3:0] w;
  logic [7:0] code;
  logic [9:0] len;
  logic [7:0] codes[8] = '{8'h01, 8'h02, 8'h03, 8'h80, 8'h00, 8'hff, 8'h00, 8'h00};
  int         num_errors = 0;
  int         checked = 0;
  int         cycles = 0;

  rdsd_source src (.clk(clk), .data_ready(dready), .first_data_input(fdi),
    .second_data_input(sdi), .data_valid(dvalid));
  rdsd_top dut (.clk(clk), .srst(srst), .first_data_input(fdi),
    .second_data_input(sdi), .data_valid(dvalid), .data_ready(dready),
    .ratio_select_bit_msb(msb), .ratio_select_mid(mid),
    .ratio_select_bit_lsb(lsb), .input_clock_phase(phase),
    .serial_out(sout), .serial_valid(sval), .sync_out(so), .sync_out_n(son));

  initial forever #5 clk = ~clk;

  // ------------------------------------------------
  // compares, expectations, verdict
  // ------------------------------------------------
  task automatic check_bits(logic [1:0] got, logic [1:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_len(logic [9:0] got, logic [9:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [9:0] ratio_of(logic [7:0] c);
    return (c == 8'h00) ? 10'h100 : {2'b00, c};
  endfunction
  task automatic push(logic [3:0] v);
    src.q.push_back(v);
    exp_q.push_back(v);
  endtask
  task automatic wait_lvl(logic v);
    while (so !== v) @(negedge clk);
  endtask
  task automatic count(logic v, output logic [9:0] n);
    n = 10'h000;
    while (so === v)
    begin
      n++;
      @(negedge clk);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // hang guard, well above the longest ratio sweep
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  // stream monitor: first bit in high phase, second bit one cycle later
  always @(negedge clk)
  begin
    if (dready === 1'b0)
      saw_full <= 1'b1;
    if (sval === 1'b1 && phase === 1'b1 && exp_q.size() != 0)
    begin
      w = exp_q.pop_front();
      check_bits(sout, w[1:0]);
      sec = w[3:2];
    end
    else if (sval === 1'b1)
      check_bits(sout, sec);
  end

  initial
  begin
    void'($urandom(32'h26482b30));
    repeat (8) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    // words arrive faster than they drain, so the fifo fills and refuses
    push(4'h0);
    push(4'hf);
    push(4'h5);
    push(4'ha);
    repeat (76) push(4'($urandom));
    while (exp_q.size() != 0) @(negedge clk);
    repeat (4) @(negedge clk);
    check_bits({saw_full, dready}, 2'b11);
    $display("test stream done");
    // ratio sweep: two rises let a new code settle before measuring
    foreach (codes[i])
    begin
      code = (i > 5) ? 8'($urandom) : codes[i];
      {msb, mid, lsb} = code;
      repeat (2)
      begin
        wait_lvl(1'b0);
        wait_lvl(1'b1);
      end
      check_bits({so, son}, 2'b10);
      count(1'b1, len);
      check_len(len, ratio_of(code));
      check_bits({so, son}, 2'b01);
      count(1'b0, len);
      check_len(len, ratio_of(code));
      $display("test ratio %h done", code);
    end
    print_verdict();
  end
endmodule
